// ### verilog/tcc_regs.svh
// Purpose: Offsets, fields, reset values of the timer channel block
// Assumes: 32-bit Wishbone words, 8-bit registers in the low byte lane
// Notes:   Operation list below
//
// Operation
// RQ1 - Capture mode sets event flag on the selected active pin edge.
// RQ2 - Compare and PWM modes set flag when counter equals channel value.
// RQ3 - PWM at 0% or 100% duty never sets the event flag.
// RQ4 - Interrupt request while flag and interrupt enable are both one.
// RQ5 - Flag clears only by read with flag set, then writing zero.
// RQ6 - A new event during the clear sequence restarts it, flag stays.
// RQ7 - Writing one to flag does nothing; reset clears flag and enable.
// RQ8 - Without center mode: 1X edge PWM, 00 capture, 01 compare.
// RQ9 - Edge/level code 00 releases the pin from all timer functions.
// RQ10 - Capture trigger: 01 rising, 10 falling, 11 either edge.
// RQ11 - Compare match: 01 toggles, 10 drives low, 11 drives high.
// RQ12 - Edge PWM: 10 high-true cleared on match, X1 low-true set.
// RQ13 - Center PWM: same polarities, acting on up-counting compare match.
// RQ14 - 16-bit channel value in two bytes, reset to zero.
// RQ15 - Capture mode reads latch both bytes until other byte is read.
// RQ16 - Any control/status write resets read and write latches.
// RQ17 - Writes to channel value bytes are ignored in capture mode.
// RQ18 - Debug freezes read latch state; reads return live value.
// RQ19 - Compare/PWM writes are buffered; no clock updates on second byte.
// RQ20 - Compare mode with clock updates at next counter change.
// RQ21 - PWM with clock updates when counter steps to modulo or 0xFFFF.
// RQ22 - Debug writes go straight to register, partial sequence kept.
// RQ23 - Software keeps pin stable two cycles before entering capture.
// RQ24 - Center select one puts the channel in center-aligned PWM.
// RQ25 - Clock source 00 means no clock, counter disabled.
// RQ26 - Pin is synchronised to the bus clock before edge detection.
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH

`define TCC_ADR_CTRL      4'h0
`define TCC_ADR_VAL_HI    4'h4
`define TCC_ADR_VAL_LO    4'h8

`define TCC_BIT_FLAG      7
`define TCC_BIT_IRQ_EN    6
`define TCC_BIT_MODE_HI   5
`define TCC_BIT_MODE_LO   4
`define TCC_BIT_EL_HI     3
`define TCC_BIT_EL_LO     2

`define TCC_CTRL_RESET    8'h00
`define TCC_VAL_RESET     16'h0000
`define TCC_FREE_TOP      16'hFFFF
`define TCC_CLK_NONE      2'h0
`define TCC_SYNC_STAGES   2

`endif

// ### verilog/tcc_pkg.sv
// Purpose: Types of the timer channel block
// Assumes: Nothing
// Notes:   One-hot channel function codes
package tcc_pkg;
  typedef enum logic [3:0] {
    TCC_CAPTURE = 4'h1,
    TCC_COMPARE = 4'h2,
    TCC_EDGE    = 4'h4,
    TCC_CENTER  = 4'h8
  } tcc_mode_type;
endpackage

// ### verilog/tcc_channel.sv
// Purpose: One capture/compare/PWM channel of a 16-bit timer unit
// Assumes: Counter, modulo and clock source come from the main timer
// Notes:   Classic Wishbone slave, ack one cycle after request
//
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "tcc_regs.svh"

module tcc_channel (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [15:0] count_i,
  input  wire logic        count_step_i,
  input  wire logic        count_down_i,
  input  wire logic [15:0] modulo_value_i,
  input  wire logic        center_pwm_select_i,
  input  wire logic [1:0]  counter_clock_source_i,
  input  wire logic        background_debug_active_i,
  input  wire logic        chan_pin_i,
  output logic             chan_pin_o,
  output logic             chan_pin_oe_o,
  output logic             chan_irq_o
);
  import tcc_pkg::*;

  // ************************************************************
  // Registers
  // ************************************************************
  logic        flag_reg;
  logic        irq_en_reg;
  logic [1:0]  mode_sel_reg;
  logic [1:0]  el_sel_reg;
  logic        clr_armed_reg;
  logic [15:0] value_reg;
  logic [15:0] rd_buf_reg;
  logic        rd_latched_reg;
  logic        rd_first_hi_reg;
  logic [15:0] wr_buf_reg;
  logic        wr_hi_done_reg;
  logic        wr_lo_done_reg;
  logic        sync1_reg;
  logic        sync2_reg;
  logic        pin_prev_reg;
  logic        pin_reg;
  logic        ack_reg;
  logic [7:0]  dat_reg;

  // ************************************************************
  // Bus decode
  // ************************************************************
  wire         access    = ce_i & wb_cyc_i & wb_stb_i & ~ack_reg;
  wire         lane0     = wb_sel_i[0];
  wire         wr        = access & wb_we_i & lane0;
  wire         rd        = access & ~wb_we_i;
  wire         hit_ctrl  = wb_adr_i == `TCC_ADR_CTRL;
  wire         hit_hi    = wb_adr_i == `TCC_ADR_VAL_HI;
  wire         hit_lo    = wb_adr_i == `TCC_ADR_VAL_LO;
  wire         wr_ctrl   = wr & hit_ctrl;
  wire         wr_hi     = wr & hit_hi;
  wire         wr_lo     = wr & hit_lo;
  wire         rd_ctrl   = rd & hit_ctrl;
  wire         rd_hi     = rd & hit_hi;
  wire         rd_lo     = rd & hit_lo;
  wire [7:0]   wdat      = wb_dat_i[7:0];
  wire         dbg       = background_debug_active_i;

  // ************************************************************
  // Mode decode
  // ************************************************************
  tcc_mode_type mode;
  assign mode = center_pwm_select_i ? TCC_CENTER :         // RQ24
                mode_sel_reg[1]     ? TCC_EDGE :            // RQ8
                mode_sel_reg[0]     ? TCC_COMPARE :
                                      TCC_CAPTURE;
  wire is_cap   = mode == TCC_CAPTURE;
  wire is_cmp   = mode == TCC_COMPARE;
  wire is_pwm   = (mode == TCC_EDGE) | (mode == TCC_CENTER);
  wire pin_used = el_sel_reg != 2'h0;                       // RQ9
  wire clk_off  = counter_clock_source_i == `TCC_CLK_NONE;  // RQ25

  // ************************************************************
  // Input edge detection
  // ************************************************************
  wire rise     = sync2_reg & ~pin_prev_reg;
  wire fall     = ~sync2_reg & pin_prev_reg;
  wire cap_hit  = is_cap & ((el_sel_reg[0] & rise) |      // RQ10
                            (el_sel_reg[1] & fall));

  // ************************************************************
  // Compare and duty decode
  // ************************************************************
  wire [15:0] top     = (modulo_value_i == 16'h0000) ?
                        `TCC_FREE_TOP : modulo_value_i;
  wire match          = count_step_i & (count_i == value_reg);
  wire duty_zero      = value_reg == 16'h0000;
  wire duty_full_edge = (modulo_value_i != 16'h0000) &
                        (value_reg > modulo_value_i);
  wire duty_full_ctr  = (modulo_value_i != 16'h0000) &
                        (value_reg >= modulo_value_i);
  wire duty_edge_end  = duty_zero | duty_full_edge;
  wire duty_ctr_end   = duty_zero | duty_full_ctr;
  wire duty_end       = (mode == TCC_EDGE) ? duty_edge_end :
                        (mode == TCC_CENTER) ? duty_ctr_end :
                        1'b0;
  wire cmp_hit        = ~is_cap & match & ~(is_pwm & duty_end); // RQ2 RQ3
  wire event_hit      = cap_hit | cmp_hit;                      // RQ1
  wire period_start   = count_step_i & (count_i == 16'h0000);
  wire hi_true        = ~el_sel_reg[0];

  // ************************************************************
  // Pin output next value
  // ************************************************************
  logic pin_next;
  always_comb begin
    pin_next = pin_reg;
    case (mode)
      TCC_COMPARE: begin
        if (match) begin
          case (el_sel_reg)                                    // RQ11
            2'h1:    pin_next = ~pin_reg;
            2'h2:    pin_next = 1'b0;
            2'h3:    pin_next = 1'b1;
            default: pin_next = pin_reg;
          endcase
        end
      end
      TCC_EDGE: begin
        if (match)                                             // RQ12
          pin_next = ~hi_true;
        else if (period_start)
          pin_next = hi_true;
      end
      TCC_CENTER: begin
        if (match & ~count_down_i)                             // RQ13
          pin_next = ~hi_true;
        else if (match & count_down_i)
          pin_next = hi_true;
      end
      default: pin_next = pin_reg;
    endcase
  end

  // ************************************************************
  // Event flag and clear sequence
  // ************************************************************
  wire clr_req   = wr_ctrl & clr_armed_reg &
                   ~wdat[`TCC_BIT_FLAG];                       // RQ5
  wire flag_next = event_hit ? 1'b1 :                          // RQ6
                   clr_req   ? 1'b0 : flag_reg;                // RQ7
  wire arm_next  = event_hit ? 1'b0 :                          // RQ6
                   wr_ctrl   ? 1'b0 :
                   (rd_ctrl & flag_reg) ? 1'b1 : clr_armed_reg;

  // ************************************************************
  // Write coherency
  // ************************************************************
  wire wr_ok     = ~is_cap;                                    // RQ17
  wire buf_hi    = wr_hi & wr_ok & ~dbg;                       // RQ19
  wire buf_lo    = wr_lo & wr_ok & ~dbg;
  wire hi_done   = wr_hi_done_reg | buf_hi;
  wire lo_done   = wr_lo_done_reg | buf_lo;
  wire both_done = wr_hi_done_reg & wr_lo_done_reg;
  wire load_cmp  = is_cmp & count_step_i;                      // RQ20
  wire load_pwm  = is_pwm & count_step_i & (count_i == top);   // RQ21
  wire load_now  = both_done & ~is_cap &
                   (clk_off | load_cmp | load_pwm);            // RQ19
  wire [15:0] wr_buf_next = {buf_hi ? wdat : wr_buf_reg[15:8],
                             buf_lo ? wdat : wr_buf_reg[7:0]};

  // ************************************************************
  // Channel value next
  // ************************************************************
  logic [15:0] value_next;
  always_comb begin
    value_next = value_reg;
    if (cap_hit)
      value_next = count_i;                                    // RQ14
    else if (load_now)
      value_next = wr_buf_reg;
    if (wr_ok & dbg & wr_hi)                                   // RQ22
      value_next[15:8] = wdat;
    if (wr_ok & dbg & wr_lo)
      value_next[7:0] = wdat;
  end

  // ************************************************************
  // Read coherency
  // ************************************************************
  wire rd_val     = rd_hi | rd_lo;
  wire rd_coh     = rd_val & is_cap & ~dbg;                    // RQ18
  wire rd_other   = rd_latched_reg & (rd_first_hi_reg ? rd_lo : rd_hi);
  wire [15:0] rd_src = (rd_latched_reg & is_cap & ~dbg) ?
                       rd_buf_reg : value_reg;                 // RQ15
  wire [7:0] ctrl_rd = {flag_reg, irq_en_reg, mode_sel_reg,
                        el_sel_reg, 2'h0};
  wire [7:0] rd_mux  = hit_ctrl ? ctrl_rd :
                       hit_hi   ? rd_src[15:8] :
                       hit_lo   ? rd_src[7:0] : 8'h00;

  // ************************************************************
  // Bus slave
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 8'h00;
    end else if (ce_i) begin
      ack_reg <= access;
      if (rd)
        dat_reg <= rd_mux;
    end
  end

  // ************************************************************
  // Control register
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_reg      <= 1'b0;                                   // RQ7
      irq_en_reg    <= 1'b0;
      mode_sel_reg  <= 2'h0;
      el_sel_reg    <= 2'h0;
      clr_armed_reg <= 1'b0;
    end else if (ce_i) begin
      flag_reg      <= flag_next;
      clr_armed_reg <= arm_next;
      if (wr_ctrl) begin
        irq_en_reg   <= wdat[`TCC_BIT_IRQ_EN];
        mode_sel_reg <= wdat[`TCC_BIT_MODE_HI:`TCC_BIT_MODE_LO];
        el_sel_reg   <= wdat[`TCC_BIT_EL_HI:`TCC_BIT_EL_LO];
      end
    end
  end

  // ************************************************************
  // Channel value and latches
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      value_reg      <= `TCC_VAL_RESET;                        // RQ14
      wr_buf_reg     <= `TCC_VAL_RESET;
      wr_hi_done_reg <= 1'b0;
      wr_lo_done_reg <= 1'b0;
    end else if (ce_i) begin
      value_reg  <= value_next;
      wr_buf_reg <= wr_buf_next;
      if (wr_ctrl | load_now) begin                            // RQ16
        wr_hi_done_reg <= 1'b0;
        wr_lo_done_reg <= 1'b0;
      end else begin
        wr_hi_done_reg <= hi_done;
        wr_lo_done_reg <= lo_done;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_buf_reg      <= `TCC_VAL_RESET;
      rd_latched_reg  <= 1'b0;
      rd_first_hi_reg <= 1'b0;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        rd_latched_reg <= 1'b0;                                // RQ16
      end else if (rd_coh & rd_other) begin
        rd_latched_reg <= 1'b0;                                // RQ15
      end else if (rd_coh & ~rd_latched_reg) begin
        rd_latched_reg  <= 1'b1;
        rd_first_hi_reg <= rd_hi;
        rd_buf_reg      <= value_reg;
      end
    end
  end

  // ************************************************************
  // Pin sampling and drive
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg    <= 1'b0;
      sync2_reg    <= 1'b0;
      pin_prev_reg <= 1'b0;
    end else if (ce_i) begin
      sync1_reg    <= chan_pin_i;                              // RQ26
      sync2_reg    <= sync1_reg;
      pin_prev_reg <= sync2_reg;                               // RQ23
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_reg       <= 1'b0;
      chan_pin_oe_o <= 1'b0;
      chan_irq_o    <= 1'b0;
    end else if (ce_i) begin
      pin_reg       <= pin_next;
      chan_pin_oe_o <= pin_used & ~is_cap;                     // RQ9
      chan_irq_o    <= flag_next & irq_en_reg;                 // RQ4
    end
  end

  assign chan_pin_o = pin_reg;
  assign wb_ack_o   = ack_reg;
  assign wb_dat_o   = {24'h000000, dat_reg};

endmodule

// ### dv/tcc_channel_props.sv
// Purpose: Port-level assertions for the timer channel
// Assumes: ce_i held high while checked
// Notes:   Bound into tcc_channel after the module
`timescale 1ns/1ps
`include "tcc_regs.svh"

module tcc_channel_props (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_ack_o,
  input  wire logic        center_pwm_select_i,
  input  wire logic        chan_pin_oe_o,
  input  wire logic        chan_irq_o
);
  // ****************************************
  // Request decode and checks
  // ****************************************
  wire       take_w = wb_cyc_i & wb_stb_i & ce_i & ~wb_ack_o;
  wire       wctl_w = take_w & wb_we_i & wb_sel_i[0]
                      & (wb_adr_i == `TCC_ADR_CTRL);
  wire [7:0] wd_w   = wb_dat_i[7:0];
  wire       plain_w = wctl_w & ~center_pwm_select_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_answer: assert property (take_w |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held beyond one cycle");
  a_irq_mask: assert property (wctl_w && !wd_w[6] |-> ##2 !chan_irq_o)
    else $error("irq with enable cleared");
  a_irq_drop_cause: assert property ($fell(chan_irq_o) |-> $past(wctl_w) || $past(wctl_w, 2))
    else $error("irq dropped without control write");
  a_pin_release: assert property (wctl_w && wd_w[3:2] == 2'h0 |-> ##2 !chan_pin_oe_o)
    else $error("pin driven with edge/level 00");
  a_capture_input: assert property (plain_w && wd_w[5:4] == 2'h0 |-> ##2 !chan_pin_oe_o)
    else $error("pin driven in capture mode");
  a_compare_drives: assert property (plain_w && wd_w[5:4] == 2'h1 && wd_w[3:2] != 2'h0
    |-> ##2 chan_pin_oe_o)
    else $error("pin not driven in compare mode");
  a_reset_quiet: assert property ($fell(rst_i) |-> !chan_irq_o && !chan_pin_oe_o)
    else $error("outputs active after reset");

  c_irq: cover property ($rose(chan_irq_o));
  c_drive: cover property ($rose(chan_pin_oe_o));
  c_clear: cover property ($fell(chan_irq_o));
endmodule

bind tcc_channel tcc_channel_props u_props (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .center_pwm_select_i(center_pwm_select_i),
  .chan_pin_oe_o(chan_pin_oe_o), .chan_irq_o(chan_irq_o));

// ### dv/tcc_pin_model.sv
// Purpose: Outside signal source and load on the channel pin
// Assumes: Source level moves only right after a clock edge
// Notes:   Resolves the wire from both drivers
`timescale 1ns/1ps

module tcc_pin_model (
  input  wire logic src_level_i,
  input  wire logic dut_pin_i,
  input  wire logic dut_oe_i,
  output logic      pin_o
);
  // Channel wins while it drives, else the outside source
  assign pin_o = dut_oe_i ? dut_pin_i : src_level_i;
endmodule

// ### dv/tcc_channel_test.sv
// Purpose: Self-checking bench for the timer channel
// Assumes: Clock enable high
// Notes:   One task per scenario
`timescale 1ns/1ps
`include "tcc_regs.svh"

module tcc_channel_test;
  localparam logic [3:0] A_CTL = `TCC_ADR_CTRL;
  localparam logic [3:0] A_HI  = `TCC_ADR_VAL_HI;
  localparam logic [3:0] A_LO  = `TCC_ADR_VAL_LO;
  logic        clk_i, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, p;
  logic        stp = 1'b0, dn = 1'b0, ctr = 1'b0, src = 1'b0;
  logic        dbg = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [7:0]  q;
  logic [1:0]  clks = 2'h0;
  logic [15:0] cnt = 16'h0000;
  logic [31:0] dat = 32'h00000000, rdat;
  logic        ack, pin, oe, irq, pin_w;
  int          errors, samples_checked, cycles;

  tcc_channel dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .count_i(cnt), .count_step_i(stp), .count_down_i(dn),
    .modulo_value_i(16'h0020), .center_pwm_select_i(ctr),
    .counter_clock_source_i(clks), .background_debug_active_i(dbg),
    .chan_pin_i(pin_w), .chan_pin_o(pin), .chan_pin_oe_o(oe),
    .chan_irq_o(irq));
  tcc_pin_model u_pin (.src_level_i(src), .dut_pin_i(pin),
    .dut_oe_i(oe), .pin_o(pin_w));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  // ****************************************
  // Bus, stimulus and compare tasks
  // ****************************************
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h000000, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rd(input string s, input logic [3:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(s, e, q);
  endtask
  task automatic step(input logic [15:0] c, input logic down);
    @(posedge clk_i);
    cnt <= c;
    dn  <= down;
    stp <= 1'b1;
    @(posedge clk_i);
    stp <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic edge_to(input logic lvl);
    src <= lvl;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic fin(input string n);
    $display("test %s done, mismatches %0d", n, errors);
  endtask

  task automatic t_capture();
    rd("ctl rst", A_CTL, 8'h00);
    rd("hi rst", A_HI, 8'h00);
    rd("unmapped", 4'hC, 8'h00);
    cnt <= 16'h1234;
    wr(A_CTL, 8'h44);
    edge_to(1'b1);
    rd("flag", A_CTL, 8'hC4);
    chk("irq", 8'h01, {7'h00, irq});
    rd("cap hi", A_HI, 8'h12);
    rd("cap lo", A_LO, 8'h34);
    wr(A_HI, 8'hAA);
    rd("hi kept", A_HI, 8'h12);
    rd("lo kept", A_LO, 8'h34);
    rd("flag", A_CTL, 8'hC4);
    wr(A_CTL, 8'h44);
    edge_to(1'b0);
    rd("rise only", A_CTL, 8'h44);
    wr(A_CTL, 8'h48);
    edge_to(1'b1);
    rd("fall only", A_CTL, 8'h48);
    edge_to(1'b0);
    rd("fall seen", A_CTL, 8'hC8);
    wr(A_CTL, 8'h0C);
    cnt <= 16'h5678;
    edge_to(1'b1);
    rd("latch hi", A_HI, 8'h56);
    cnt <= 16'h9ABC;
    edge_to(1'b0);
    rd("latched lo", A_LO, 8'h78);
    rd("live hi", A_HI, 8'h9A);
    wr(A_CTL, 8'h0C);
    cnt <= 16'h1111;
    edge_to(1'b1);
    rd("unlatched", A_LO, 8'h11);
    wr(A_CTL, 8'h0C);
    rd("no read", A_CTL, 8'h8C);
    edge_to(1'b0);
    wr(A_CTL, 8'h0C);
    rd("new event", A_CTL, 8'h8C);
    wr(A_CTL, 8'h0C);
    rd("cleared", A_CTL, 8'h0C);
    wr(A_CTL, 8'h8C);
    rd("write one", A_CTL, 8'h0C);
    fin("capture");
  endtask

  task automatic t_compare();
    wr(A_CTL, 8'h14);
    wr(A_HI, 8'h00);
    wr(A_LO, 8'h40);
    for (int e = 1; e < 4; e++) begin
      acc(1'b0, A_CTL, 8'h00);
      wr(A_CTL, {4'h1, e[1:0], 2'h0});
      repeat (2) @(posedge clk_i);
      p = pin;
      step(16'h0040, 1'b0);
      chk("cmp pin", {7'h00, e == 1 ? ~p : e == 3}, {7'h00, pin});
      rd("cmp flag", A_CTL, {4'h9, e[1:0], 2'h0});
    end
    wr(A_CTL, 8'h14);
    clks <= 2'h1;
    wr(A_HI, 8'h00);
    wr(A_LO, 8'h50);
    step(16'h0041, 1'b0);
    p = pin;
    step(16'h0050, 1'b0);
    chk("cmp update", {7'h00, ~p}, {7'h00, pin});
    fin("compare");
  endtask

  task automatic t_pwm();
    clks <= 2'h0;
    for (int k = 0; k < 4; k++) begin
      ctr <= k[1];
      wr(A_CTL, k[0] ? 8'h24 : 8'h28);
      wr(A_HI, 8'h00);
      wr(A_LO, 8'h08);
      step(k[1] ? 16'h0008 : 16'h0000, k[1]);
      chk("pwm first", {7'h00, ~k[0]}, {7'h00, pin});
      step(16'h0008, 1'b0);
      chk("pwm match up", {7'h00, k[0]}, {7'h00, pin});
    end
    ctr <= 1'b0;
    acc(1'b0, A_CTL, 8'h00);
    wr(A_CTL, 8'h28);
    wr(A_HI, 8'h00);
    wr(A_LO, 8'h00);
    step(16'h0000, 1'b0);
    rd("zero duty", A_CTL, 8'h28);
    fin("pwm");
  endtask

  task automatic t_debug();
    clks <= 2'h1;
    wr(A_CTL, 8'h28);
    wr(A_HI, 8'h00);
    wr(A_LO, 8'h10);
    rd("pwm held", A_LO, 8'h00);
    step(16'h001F, 1'b0);
    rd("pwm early", A_LO, 8'h00);
    step(16'h0020, 1'b0);
    rd("pwm load", A_LO, 8'h10);
    dbg <= 1'b1;
    wr(A_LO, 8'h33);
    rd("dbg write", A_LO, 8'h33);
    cnt <= 16'h2468;
    wr(A_CTL, 8'h0C);
    edge_to(~src);
    rd("dbg hi", A_HI, 8'h24);
    cnt <= 16'h1357;
    edge_to(~src);
    rd("dbg lo", A_LO, 8'h57);
    dbg <= 1'b0;
    fin("debug");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_capture();
    t_compare();
    t_pwm();
    t_debug();
    tally_and_finish();
  end
endmodule
